// [hcm_mailbox.sv]
`default_nettype none
// What this block does
// - channel pointer keeps a two-bit channel number in its low bits
// - two-channel build refuses channel two or three with invalid response
// - command register holds eight-bit code, upper byte reads zero
// - execution starts only once a nonzero code is seen
// - while executing, every read returns the identity word
// - on completion command clears to zero and response is posted
// - sixteen-bit response codes 1, 2, 0x10, 3, 4, 5
// - three parameter words hold host writes and processor results; only the host reads them
// - configuration readable at once, effective when next command starts
// - config bits 15 and 14 skip converter calibration and verify
// - config bit 3 suppresses lamp flashing, set after reset
// - config bit 2 darkens lamp; firmware sets by self-test outcome
// - config bit 1 selects offset binary, zero two's complement
// - config bit 0 echoes corrected samples into host buffer
// - failure flags per channel, cleared at calibration start
// - reset flag 0x1D on reset, cleared by calibration or coeff load
// - revision register: major high byte, minor low byte
// - engine status refreshed only by report command
// - request flag set by trigger start, cleared by end pointer write
// - engine state codes 000,001,011,100,110,111
module hcm_mailbox (
    input wire logic clk,
    input wire logic rst,
    input wire logic twoChannel,
    // host register port, 16-bit words
    input wire logic hostWrite,
    input wire logic hostRead,
    input wire logic [7:0] hostAddr,
    input wire logic [1:0] hostByteEn,
    input wire logic [15:0] hostWrData,
    output logic [15:0] hostRdData,
    output logic hostRdValid,
    // processor side
    output logic cmdPending,
    output logic [7:0] commandCode,
    output logic [1:0] channelSelect,
    output logic [15:0] activeConfig,
    input wire logic procDone,
    input wire logic procCodeKnown,
    input wire logic [15:0] procResponse,
    input wire logic procParamWrite,
    input wire logic [15:0] procParam,
    input wire logic [15:0] procAuxLow,
    input wire logic [15:0] procAuxHigh,
    input wire logic procSelftestResult,
    input wire logic procSelftestPass,
    input wire logic [3:0] procFailFlags,
    input wire logic procCalStart,
    input wire logic procCoeffLoad,
    input wire logic procReportStatus,
    input wire logic [11:0] engineCodes,
    input wire logic [3:0] triggerStart,
    input wire logic [3:0] endPtrWrite,
    input wire logic procBootDone,
    // lamp outputs
    output logic lampOn,
    output logic lampFlashEnable
);
    hcm_pkg::hcm_state_t state_r;
    logic [15:0] chPtr_r;
    logic [7:0] cmd_r;
    logic [15:0] param_r;
    logic [15:0] resp_r;
    logic [15:0] cfg_r;
    logic [15:0] cfgActive_r;
    logic [3:0] fail_r;
    logic [15:0] rstFlag_r;
    logic [15:0] auxLo_r;
    logic [15:0] auxHi_r;
    logic [15:0] engWord [4];
    logic accept;
    logic busy;

    // merge bytes of a host write into a stored word
    function automatic logic [15:0] merge(input logic [15:0] old,
            input logic [15:0] wr, input logic [1:0] be);
        logic [15:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wr[7:0];
        end
        if (be[1]) begin
            res[15:8] = wr[15:8];
        end
        return res;
    endfunction

    // host write hits a given offset while block is free
    function automatic logic hit(input logic [7:0] addr,
            input logic [7:0] off, input logic wr, input logic bz);
        return wr && !bz && (addr == off);
    endfunction

    assign busy = (state_r != hcm_hlp_idle());

    function automatic hcm_pkg::hcm_state_t hcm_hlp_idle();
        return hcm_pkg::HCM_IDLE;
    endfunction

    hcm_cmd_check u_check (
        .commandCode(cmd_r),
        .channelSelect(chPtr_r[1:0]),
        .twoChannel(twoChannel),
        .codeKnown(procCodeKnown),
        .accept(accept)
    );

    // command sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= hcm_pkg::HCM_IDLE;
        end else begin
            unique case (state_r)
                hcm_pkg::HCM_IDLE: begin
                    if (cmd_r != 8'h00) begin
                        state_r <= hcm_pkg::HCM_BUSY;
                    end
                end
                hcm_pkg::HCM_BUSY: begin
                    if (!accept || procDone) begin
                        state_r <= hcm_pkg::HCM_FINISH;
                    end
                end
                hcm_pkg::HCM_FINISH: begin
                    state_r <= hcm_pkg::HCM_IDLE;
                end
            endcase
        end
    end

    // command mailbox, cleared by the sequencer on finish
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_r <= 8'h00;
        end else if (state_r == hcm_pkg::HCM_FINISH) begin
            cmd_r <= 8'h00;
        end else if (hit(hostAddr, hcm_pkg::OFF_CMD, hostWrite, busy)
                && hostByteEn[0]) begin
            cmd_r <= hostWrData[7:0];
        end
    end

    // response register: posted on finish, boot code after startup
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resp_r <= 16'h0000;
        end else if (state_r == hcm_pkg::HCM_BUSY && !accept) begin
            resp_r <= hcm_pkg::RESP_INVALID;
        end else if (state_r == hcm_pkg::HCM_BUSY && procDone) begin
            resp_r <= procResponse;
        end else if (procBootDone) begin
            resp_r <= hcm_pkg::RESP_BOOT;
        end else if (hit(hostAddr, hcm_pkg::OFF_RESP, hostWrite, busy)) begin
            resp_r <= merge(resp_r, hostWrData, hostByteEn);
        end
    end

    // channel pointer and parameter words
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chPtr_r <= 16'h0000;
            param_r <= 16'h0000;
            auxLo_r <= 16'h0000;
            auxHi_r <= 16'h0000;
        end else if (busy && procParamWrite) begin
            param_r <= procParam;
            auxLo_r <= procAuxLow;
            auxHi_r <= procAuxHigh;
        end else begin
            if (hit(hostAddr, hcm_pkg::OFF_CHPTR, hostWrite, busy)) begin
                chPtr_r <= merge(chPtr_r, hostWrData, hostByteEn);
            end
            if (hit(hostAddr, hcm_pkg::OFF_PARAM, hostWrite, busy)) begin
                param_r <= merge(param_r, hostWrData, hostByteEn);
            end
            if (hit(hostAddr, hcm_pkg::OFF_AUXLO, hostWrite, busy)) begin
                auxLo_r <= merge(auxLo_r, hostWrData, hostByteEn);
            end
            if (hit(hostAddr, hcm_pkg::OFF_AUXHI, hostWrite, busy)) begin
                auxHi_r <= merge(auxHi_r, hostWrData, hostByteEn);
            end
        end
    end

    // configuration: stored value visible, active copy taken at command
    // self-test verdict drives the lamp at once, power-up test included, save in a cycle where a command is taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_r <= hcm_pkg::CFG_RESET;
            cfgActive_r <= hcm_pkg::CFG_RESET;
        end else begin
            if (procSelftestResult) begin
                cfg_r[hcm_pkg::CFG_LAMP_DARK] <= procSelftestPass;
            end else if (hit(hostAddr, hcm_pkg::OFF_CFG, hostWrite, busy)) begin
                cfg_r <= merge(cfg_r, hostWrData, hostByteEn)
                    & hcm_pkg::CFG_MASK;
            end
            if (state_r == hcm_pkg::HCM_IDLE && cmd_r != 8'h00) begin
                cfgActive_r <= cfg_r;
            end else if (procSelftestResult) begin
                cfgActive_r[hcm_pkg::CFG_LAMP_DARK] <= procSelftestPass;
            end
        end
    end

    // self-test failure flags; cleared when calibration begins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fail_r <= 4'h0;
        end else if (procCalStart) begin
            fail_r <= 4'h0;
        end else if (procSelftestResult) begin
            fail_r <= procFailFlags | fail_r;
        end
    end

    // reset flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rstFlag_r <= hcm_pkg::RSTFLAG_SET;
        end else if (procCalStart || procCoeffLoad) begin
            rstFlag_r <= 16'h0000;
        end
    end

    // per-channel engine status words
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_eng
            hcm_engine_status u_eng (
                .clk(clk),
                .rst(rst),
                .refresh(busy && procReportStatus),
                .engineCode(engineCodes[3*g +: 3]),
                .triggerStart(triggerStart[g]),
                .endPtrWrite(endPtrWrite[g]),
                .statusWord(engWord[g])
            );
        end
    endgenerate

    // host read data, identity while a command runs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hostRdData <= 16'h0000;
            hostRdValid <= 1'b0;
        end else begin
            hostRdValid <= hostRead;
            if (!hostRead) begin
                hostRdData <= hostRdData;
            end else if (busy) begin
                hostRdData <= hcm_pkg::BOARD_ID;
            end else begin
                unique case (hostAddr)
                    hcm_pkg::OFF_IDENT: hostRdData <= hcm_pkg::BOARD_ID;
                    hcm_pkg::OFF_CHPTR: hostRdData <= chPtr_r;
                    hcm_pkg::OFF_CMD: hostRdData <= {8'h00, cmd_r};
                    hcm_pkg::OFF_PARAM: hostRdData <= param_r;
                    hcm_pkg::OFF_RESP: hostRdData <= resp_r;
                    hcm_pkg::OFF_CFG: hostRdData <= cfg_r;
                    hcm_pkg::OFF_STFAIL: begin
                        hostRdData <= {12'h000,
                            twoChannel ? 2'b00 : fail_r[3:2],
                            fail_r[1:0]};
                    end
                    hcm_pkg::OFF_RSTFLAG: hostRdData <= rstFlag_r;
                    hcm_pkg::OFF_AUXLO: hostRdData <= auxLo_r;
                    hcm_pkg::OFF_AUXHI: hostRdData <= auxHi_r;
                    hcm_pkg::OFF_FWREV: hostRdData <= hcm_pkg::FW_REV;
                    hcm_pkg::OFF_ENG0: hostRdData <= engWord[0];
                    hcm_pkg::OFF_ENG1: hostRdData <= engWord[1];
                    hcm_pkg::OFF_ENG2: hostRdData <= engWord[2];
                    hcm_pkg::OFF_ENG3: hostRdData <= engWord[3];
                    default: hostRdData <= 16'h0000;
                endcase
            end
        end
    end

    // processor side view
    assign cmdPending = (state_r == hcm_pkg::HCM_BUSY) && accept;
    assign commandCode = cmd_r;
    assign channelSelect = chPtr_r[1:0];
    assign activeConfig = cfgActive_r;
    assign lampOn = !cfgActive_r[hcm_pkg::CFG_LAMP_DARK];
    assign lampFlashEnable = !cfgActive_r[hcm_pkg::CFG_NO_BLINK];
endmodule
`default_nettype wire

// [hcm_pkg.sv]
`default_nettype none
package hcm_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_IDENT = 8'h00;
    localparam logic [7:0] OFF_CHPTR = 8'h02;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_PARAM = 8'h06;
    localparam logic [7:0] OFF_RESP = 8'h08;
    localparam logic [7:0] OFF_CFG = 8'h0A;
    localparam logic [7:0] OFF_STFAIL = 8'h0C;
    localparam logic [7:0] OFF_RSTFLAG = 8'h0E;
    localparam logic [7:0] OFF_AUXLO = 8'h16;
    localparam logic [7:0] OFF_AUXHI = 8'h18;
    localparam logic [7:0] OFF_FWREV = 8'h1E;
    localparam logic [7:0] OFF_ENG0 = 8'h20;
    localparam logic [7:0] OFF_ENG1 = 8'h22;
    localparam logic [7:0] OFF_ENG2 = 8'h24;
    localparam logic [7:0] OFF_ENG3 = 8'h26;
    // identity word, value arbitrary
    localparam logic [15:0] BOARD_ID = 16'h5A00;
    localparam logic [15:0] FW_REV = 16'h0100;
    localparam logic [15:0] RSTFLAG_SET = 16'h001D;
    localparam logic [15:0] CFG_RESET = 16'h0008;
    localparam logic [15:0] CFG_MASK = 16'hC00F;
    // response codes
    localparam logic [15:0] RESP_VALID = 16'h0001;
    localparam logic [15:0] RESP_INVALID = 16'h0002;
    localparam logic [15:0] RESP_BOOT = 16'h0010;
    localparam logic [15:0] RESP_LOADED = 16'h0003;
    localparam logic [15:0] RESP_CALLOAD = 16'h0004;
    localparam logic [15:0] RESP_CLIPPED = 16'h0005;
    // configuration bit positions, then the engine status request flag bit
    localparam int CFG_SKIP_CAL = 15;
    localparam int CFG_SKIP_VER = 14;
    localparam int CFG_NO_BLINK = 3;
    localparam int CFG_LAMP_DARK = 2;
    localparam int CFG_FORMAT = 1;
    localparam int CFG_ECHO = 0;
    localparam int SEGMENT_REQUEST_FLAG_BIT = 3;
    // engine state codes
    localparam logic [2:0] ENG_INIT = 3'h0;
    localparam logic [2:0] ENG_LOAD = 3'h1;
    localparam logic [2:0] ENG_ARM = 3'h3;
    localparam logic [2:0] ENG_DONE = 3'h4;
    localparam logic [2:0] ENG_IDLE = 3'h6;
    localparam logic [2:0] ENG_WAVE = 3'h7;
    typedef enum logic [1:0] {HCM_IDLE, HCM_BUSY, HCM_FINISH} hcm_state_t;
endpackage
`default_nettype wire

// [hcm_engine_status.sv]
`default_nettype none
// one channel's engine status word, refreshed on report command
module hcm_engine_status (
    input wire logic clk,
    input wire logic rst,
    input wire logic refresh,
    input wire logic [2:0] engineCode,
    input wire logic triggerStart,
    input wire logic endPtrWrite,
    output logic [15:0] statusWord
);
    logic segment_request_flag_r;

    // request flag: trigger set beats end pointer clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            segment_request_flag_r <= 1'b0;
        end else if (triggerStart) begin
            segment_request_flag_r <= 1'b1;
        end else if (endPtrWrite) begin
            segment_request_flag_r <= 1'b0;
        end
    end

    // snapshot taken only when report command runs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            statusWord <= '0;
        end else if (refresh) begin
            statusWord <= {12'h000, segment_request_flag_r, engineCode};
        end
    end
endmodule
`default_nettype wire

// [hcm_cmd_check.sv]
`default_nettype none
// validates a command against the channel pointer
module hcm_cmd_check (
    input wire logic [7:0] commandCode,
    input wire logic [1:0] channelSelect,
    input wire logic twoChannel,
    input wire logic codeKnown,
    output logic accept
);
    // upper channels refused on two-channel build
    always_comb begin
        accept = codeKnown && !(twoChannel && channelSelect[1]);
        if (commandCode == 8'h00) begin
            accept = 1'b0;
        end
    end
endmodule
`default_nettype wire

// [hcm_mailbox_monitor.sv]
`default_nettype none
module hcm_mailbox_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic twoChannel,
    input wire logic hostWrite,
    input wire logic hostRead,
    input wire logic [7:0] hostAddr,
    input wire logic [15:0] hostRdData,
    input wire logic hostRdValid,
    input wire logic cmdPending,
    input wire logic [7:0] commandCode,
    input wire logic [1:0] channelSelect,
    input wire logic [15:0] activeConfig,
    input wire logic procDone,
    input wire logic procSelftestResult,
    input wire logic lampOn,
    input wire logic lampFlashEnable
);
    // one clock domain, reset disables every check
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_read_answer: assert property (hostRead |=> hostRdValid)
        else $error("read not answered in the next cycle");
    chk_busy_ident: assert property (hostRead && cmdPending |=>
        hostRdData == hcm_pkg::BOARD_ID)
        else $error("read while busy did not give identity word");
    chk_start_nonzero: assert property ($rose(cmdPending) |->
        commandCode != 8'h00)
        else $error("command started on a zero code");
    chk_pending_holds: assert property (cmdPending && !procDone |=>
        cmdPending)
        else $error("command ended without done");
    chk_done_drops: assert property (cmdPending && procDone |->
        ##2 !cmdPending)
        else $error("command still pending after done");
    chk_two_chan: assert property (twoChannel && cmdPending |->
        !channelSelect[1])
        else $error("upper channel accepted on two-channel build");
    chk_lamp_level: assert property (lampOn ==
        !activeConfig[hcm_pkg::CFG_LAMP_DARK])
        else $error("lamp level differs from config");
    chk_blink_level: assert property (lampFlashEnable ==
        !activeConfig[hcm_pkg::CFG_NO_BLINK])
        else $error("flash enable differs from config");
    chk_cfg_deferred: assert property (hostWrite &&
        commandCode == 8'h00 && !procSelftestResult &&
        hostAddr == hcm_pkg::OFF_CFG |=> $stable(activeConfig))
        else $error("config took effect before a command");
endmodule
bind hcm_mailbox hcm_mailbox_chk chk_u (.clk, .rst, .twoChannel,
    .hostWrite, .hostRead, .hostAddr, .hostRdData, .hostRdValid,
    .cmdPending, .commandCode, .channelSelect, .activeConfig, .procDone,
    .procSelftestResult, .lampOn, .lampFlashEnable);
`default_nettype wire

// [hcm_proc_model.sv]
`default_nettype none
module hcm_proc_model #(
    parameter logic [7:0] CAL_CODE = 8'h30,
    parameter logic [7:0] REPORT_CODE = 8'h11
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmdPending,
    input wire logic [7:0] commandCode,
    output logic procDone,
    output logic procCodeKnown,
    output logic [15:0] procResponse,
    output logic procParamWrite,
    output logic [15:0] procParam,
    output logic procCalStart,
    output logic procReportStatus
);
    logic [7:0] waitCnt_r;
    logic [7:0] latency;
    logic fire;
    // odd codes answer promptly, even ones slowly; all-ones is unknown
    assign latency = commandCode[0] ? 8'h01 : 8'h06;
    assign procCodeKnown = (commandCode != 8'hFF);
    assign fire = cmdPending && (waitCnt_r == latency);
    // busy cycle count, only while an accepted code runs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitCnt_r <= 8'h00;
        end else if (!cmdPending) begin
            waitCnt_r <= 8'h00;
        end else if (waitCnt_r != 8'hFF) begin
            waitCnt_r <= waitCnt_r + 8'h01;
        end
    end
    // results, side effects and response posted with done
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            procDone <= 1'b0;
            procParamWrite <= 1'b0;
            procCalStart <= 1'b0;
            procReportStatus <= 1'b0;
            procParam <= 16'h0000;
            procResponse <= 16'h0000;
        end else begin
            procDone <= fire;
            procParamWrite <= fire;
            procParam <= {commandCode, 8'hA5};
            procCalStart <= fire && commandCode == CAL_CODE;
            procReportStatus <= fire && commandCode == REPORT_CODE;
            procResponse <= (commandCode == 8'h06) ? hcm_pkg::RESP_LOADED :
                (commandCode == 8'h23) ? hcm_pkg::RESP_CALLOAD :
                hcm_pkg::RESP_VALID;
        end
    end
endmodule
`default_nettype wire

// [testbench.sv]
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [7:0] a;
        logic [15:0] d;
        logic [15:0] e;
    } hcm_tb_row_t;
    logic clk, rst, twoChannel, hostWrite, hostRead, hostRdValid;
    logic [7:0] hostAddr, commandCode;
    logic [1:0] hostByteEn, channelSelect;
    logic [15:0] hostWrData, hostRdData, activeConfig, procResponse;
    logic [15:0] procParam, procAuxLow, procAuxHigh, v;
    logic cmdPending, procDone, procCodeKnown, procParamWrite, procCalStart;
    logic procSelftestResult, procSelftestPass, procCoeffLoad, procBootDone;
    logic procReportStatus, lampOn, lampFlashEnable;
    logic [3:0] procFailFlags, triggerStart, endPtrWrite;
    logic [11:0] engineCodes;
    int n_fail = 0;
    int num_checks = 0;
    hcm_tb_row_t rows [10] = '{
        '{hcm_pkg::OFF_CHPTR, 16'h0001, 16'h0001},
        '{hcm_pkg::OFF_PARAM, 16'hBEEF, 16'hBEEF},
        '{hcm_pkg::OFF_AUXLO, 16'h1357, 16'h1357},
        '{hcm_pkg::OFF_AUXHI, 16'h2468, 16'h2468},
        '{hcm_pkg::OFF_RESP, 16'h00AA, 16'h00AA},
        '{hcm_pkg::OFF_CFG, 16'hFFFF, hcm_pkg::CFG_MASK},
        '{hcm_pkg::OFF_IDENT, 16'h1234, hcm_pkg::BOARD_ID},
        '{hcm_pkg::OFF_FWREV, 16'h0000, hcm_pkg::FW_REV},
        '{hcm_pkg::OFF_RSTFLAG, 16'h0000, hcm_pkg::RSTFLAG_SET},
        '{8'h40, 16'hFFFF, 16'h0000}
    };
    hcm_mailbox dut_u (.clk, .rst, .twoChannel, .hostWrite, .hostRead,
        .hostAddr, .hostByteEn, .hostWrData, .hostRdData, .hostRdValid,
        .cmdPending, .commandCode, .channelSelect, .activeConfig, .procDone,
        .procCodeKnown, .procResponse, .procParamWrite, .procParam,
        .procAuxLow, .procAuxHigh, .procSelftestResult, .procSelftestPass,
        .procFailFlags, .procCalStart, .procCoeffLoad, .procReportStatus,
        .engineCodes, .triggerStart, .endPtrWrite, .procBootDone, .lampOn,
        .lampFlashEnable);
    hcm_proc_model proc_u (.clk, .rst, .cmdPending, .commandCode, .procDone,
        .procCodeKnown, .procResponse, .procParamWrite, .procParam,
        .procCalStart, .procReportStatus);
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // host word write, strobe for one taken edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        hostAddr <= a;
        hostWrData <= d;
        hostWrite <= 1'b1;
        @(posedge clk);
        hostWrite <= 1'b0;
        @(posedge clk);
    endtask
    // host read, data taken at the edge where valid is seen high
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        hostAddr <= a;
        hostRead <= 1'b1;
        @(posedge clk);
        hostRead <= 1'b0;
        @(posedge clk);
        d = hostRdData;
        check(16'(hostRdValid), 16'h0001);
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        check(d, e);
    endtask
    // issue a command, poll until cleared, then read the response
    task automatic runCmd(input logic [7:0] code, input logic [15:0] resp);
        logic [15:0] d;
        wr(hcm_pkg::OFF_CMD, {8'h00, code});
        d = 16'hFFFF;
        for (int i = 0; i < 40 && d !== 16'h0000; i++)
            rd(hcm_pkg::OFF_CMD, d);
        check(d, 16'h0000);
        rc(hcm_pkg::OFF_RESP, resp);
    endtask
    task automatic engChk(input logic segment_request_flag);
        for (int i = 0; i < 4; i++)
            rc(hcm_pkg::OFF_ENG0 + 8'(2 * i),
                {12'h000, segment_request_flag && i == 1, engineCodes[3 * i +: 3]});
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // watchdog, about five thousand cycles
    initial begin
        #100000;
        n_fail++;
        conclude();
    end
    // main sequence
    initial begin
        {rst, twoChannel, hostWrite, hostRead, procSelftestResult} = 5'h10;
        {procSelftestPass, procCoeffLoad, procBootDone} = 3'h0;
        {hostAddr, hostWrData, hostByteEn} = 26'h0000003;
        {procFailFlags, triggerStart, endPtrWrite, engineCodes} = 24'h0;
        procAuxLow = 16'h0F0F;
        procAuxHigh = 16'hF0F0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            check(v, rows[i].e);
        end
        $display("register rows done");
        check(activeConfig, hcm_pkg::CFG_RESET);
        wr(hcm_pkg::OFF_CFG, 16'h0006);
        runCmd(8'h06, hcm_pkg::RESP_LOADED);
        check(activeConfig, 16'h0006);
        check(16'(lampOn), 16'h0000);
        check(16'(lampFlashEnable), 16'h0001);
        rc(hcm_pkg::OFF_PARAM, 16'h06A5);
        rc(hcm_pkg::OFF_AUXLO, 16'h0F0F);
        runCmd(8'h23, hcm_pkg::RESP_CALLOAD);
        runCmd(8'hFF, hcm_pkg::RESP_INVALID);
        twoChannel <= 1'b1;
        wr(hcm_pkg::OFF_CHPTR, 16'h0002);
        runCmd(8'h05, hcm_pkg::RESP_INVALID);
        wr(hcm_pkg::OFF_CHPTR, 16'h0001);
        runCmd(8'h05, hcm_pkg::RESP_VALID);
        $display("command tests done");
        procFailFlags <= 4'hF;
        procSelftestResult <= 1'b1;
        @(posedge clk);
        procSelftestResult <= 1'b0;
        @(posedge clk);
        rc(hcm_pkg::OFF_STFAIL, 16'h0003);
        rc(hcm_pkg::OFF_CFG, 16'h0002);
        runCmd(8'h30, hcm_pkg::RESP_VALID);
        rc(hcm_pkg::OFF_STFAIL, 16'h0000);
        rc(hcm_pkg::OFF_RSTFLAG, 16'h0000);
        {twoChannel, procSelftestPass, procSelftestResult} <= 3'h3;
        procFailFlags <= 4'h0;
        @(posedge clk);
        procSelftestResult <= 1'b0;
        @(posedge clk);
        rc(hcm_pkg::OFF_CFG, 16'h0006);
        $display("self-test tests done");
        engineCodes <= {hcm_pkg::ENG_WAVE, hcm_pkg::ENG_IDLE,
            hcm_pkg::ENG_ARM, hcm_pkg::ENG_LOAD};
        triggerStart <= 4'h2;
        @(posedge clk);
        triggerStart <= 4'h0;
        @(posedge clk);
        rc(hcm_pkg::OFF_ENG0, 16'h0000);
        runCmd(8'h11, hcm_pkg::RESP_VALID);
        engChk(1'b1);
        endPtrWrite <= 4'h2;
        engineCodes <= {hcm_pkg::ENG_INIT, hcm_pkg::ENG_DONE,
            hcm_pkg::ENG_ARM, hcm_pkg::ENG_DONE};
        @(posedge clk);
        endPtrWrite <= 4'h0;
        runCmd(8'h11, hcm_pkg::RESP_VALID);
        engChk(1'b0);
        procBootDone <= 1'b1;
        @(posedge clk);
        procBootDone <= 1'b0;
        @(posedge clk);
        rc(hcm_pkg::OFF_RESP, hcm_pkg::RESP_BOOT);
        $display("engine status tests done");
        rst <= 1'b1;
        @(negedge clk);
        check(16'(lampOn), 16'h0001);
        check(16'(lampFlashEnable), 16'h0000);
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rc(hcm_pkg::OFF_CFG, hcm_pkg::CFG_RESET);
        rc(hcm_pkg::OFF_RSTFLAG, hcm_pkg::RSTFLAG_SET);
        procCoeffLoad <= 1'b1;
        @(posedge clk);
        procCoeffLoad <= 1'b0;
        rc(hcm_pkg::OFF_RSTFLAG, 16'h0000);
        $display("reset tests done");
        conclude();
    end
endmodule
`default_nettype wire
